/* File: dv/pslp_host.sv */
`timescale 1ns/1ps
module pslp_host
  import pslp_pkg::*;
#(
  parameter int SETTLE = 40
) (
  // clock
  input wire logic clk_i,
  // serial pins to device
  output logic sclk_o,
  output logic sdata_o,
  output logic load_strobe_o
);
  // serial clock idles low between frames
  initial begin
    sclk_o = 1'b0;
    sdata_o = 1'b0;
    load_strobe_o = 1'b0;
  end

  task automatic send(input logic [WORD_W-1:0] w);
    for (int i = WORD_W - 1; i >= 0; i--) begin
      @(posedge clk_i);
      sdata_o <= w[i];
      repeat (3) @(posedge clk_i);
      sclk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b0;
    end
    repeat (4) @(posedge clk_i);
    load_strobe_o <= 1'b1;
    @(posedge clk_i);
    // hold over: data no longer meaningful
    sdata_o <= ~w[0];
    repeat (3) @(posedge clk_i);
    load_strobe_o <= 1'b0;
  endtask : send

  // scaled down, the device does not time this gap
  task automatic settle();
    repeat (SETTLE) @(posedge clk_i);
  endtask : settle
endmodule : pslp_host

/* File: dv/pslp_latch_bank_properties.sv */
`timescale 1ns/1ps
module pslp_props
  import pslp_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // pin level
  input wire logic chip_enable_i,
  // watched outputs
  input wire pslp_ctrl_t ctrl_o,
  input wire pslp_fb_t fb_o,
  input wire pslp_ref_t ref_o,
  input wire pslp_pd_t pd_o,
  input wire logic band_select_active_o,
  input wire logic test_latch_write_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  AST_CE_OFF: assert property (!chip_enable_i [*4] |-> pd_o.powered_down)
    else $error("chip enable low left device running");
  // five samples cover the two-cycle pin sync with margin, power-up has no further lag
  AST_UP: assert property ((chip_enable_i && !ctrl_o.powerdown_request) [*5]
    |-> !pd_o.powered_down) else $error("device stayed down");
  AST_ASYNC: assert property ($rose(ctrl_o.powerdown_request)
    && !ctrl_o.powerdown_sync_sel |-> ##[0:1] pd_o.powered_down)
    else $error("async power-down late");
  AST_SYNC: assert property ($rose(ctrl_o.powerdown_request)
    && ctrl_o.powerdown_sync_sel && chip_enable_i |-> !pd_o.powered_down)
    else $error("sync power-down did not wait");
  AST_PD_ALL: assert property (pd_o.powered_down |-> &{pd_o.dividers_held,
    pd_o.pump_hiz, pd_o.lock_reset, pd_o.rf_hiz, pd_o.ref_buf_off})
    else $error("power-down effect missing");
  AST_PUMP: assert property (ctrl_o.pump_tristate [*3] |-> pd_o.pump_hiz)
    else $error("pump not three-state");
  AST_BAND_DOWN: assert property (pd_o.powered_down [*2] |-> !band_select_active_o)
    else $error("band select alive in power-down");
  AST_FB_BAND: assert property ($changed(fb_o) && !pd_o.powered_down
    |-> ##[0:2] band_select_active_o) else $error("band select not started");
  AST_TEST_PULSE: assert property (test_latch_write_o |=> !test_latch_write_o)
    else $error("test pulse too long");
  AST_TEST_KEEP: assert property (test_latch_write_o |-> $stable(ctrl_o)
    && $stable(fb_o) && $stable(ref_o)) else $error("test word changed a latch");
endmodule : pslp_props

/* File: dv/tb.sv */
`timescale 1ns/1ps
module tb
  import pslp_pkg::*;
;
  logic clk_i;
  logic rst_n_i;
  logic sclk_i;
  logic sdata_i;
  logic load_strobe_i;
  logic chip_enable_i;
  logic ref_div_out_i;
  pslp_ctrl_t ctrl_o;
  pslp_fb_t fb_o;
  pslp_ref_t ref_o;
  logic pump_gain_sel_o;
  pslp_pd_t pd_o;
  logic band_select_active_o;
  logic test_latch_write_o;
  int n_fail = 0;
  int n_checks = 0;
  int n_test = 0;
  int t0;
  int seed = 32'hF88D;
  logic [WORD_W-1:0] r, c, f;

  pslp_latch_bank dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk_i),
    .sdata_i(sdata_i), .load_strobe_i(load_strobe_i), .chip_enable_i(chip_enable_i),
    .ref_div_out_i(ref_div_out_i), .ctrl_o(ctrl_o), .fb_o(fb_o), .ref_o(ref_o),
    .pump_gain_sel_o(pump_gain_sel_o), .pd_o(pd_o),
    .band_select_active_o(band_select_active_o), .test_latch_write_o(test_latch_write_o));
  pslp_host host_u (.clk_i(clk_i), .sclk_o(sclk_i), .sdata_o(sdata_i),
    .load_strobe_o(load_strobe_i));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) if (test_latch_write_o === 1'b1) n_test++;

  function automatic logic [WORD_W-1:0] rnd(input logic [1:0] sel);
    logic [WORD_W-1:0] v;
    v = WORD_W'($random(seed));
    v[1:0] = sel;
    if (sel == SEL_REF) v[23:19] = 5'h00;
    if (sel == SEL_FB) v[7] = 1'b0;
    if (sel == SEL_CTRL) v[21:20] = 2'h0;
    return v;
  endfunction : rnd

  function automatic logic [31:0] x_ctrl(input logic [WORD_W-1:0] v);
    return 32'({v[23:11], v[9:2]});
  endfunction : x_ctrl

  function automatic logic [31:0] x_fb(input logic [WORD_W-1:0] v);
    return 32'({v[23:22], v[20:8], v[6:2]});
  endfunction : x_fb

  function automatic logic [31:0] x_pd(input logic dn, input logic tri_bit);
    return dn ? 32'h3F : 32'({2'h0, tri_bit, 3'h0});
  endfunction : x_pd

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : wt

  task automatic wr(input logic [WORD_W-1:0] v);
    host_u.send(v);
    wt(5);
  endtask : wr

  task automatic refp(input int n);
    repeat (n) begin
      @(posedge clk_i);
      ref_div_out_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      ref_div_out_i <= 1'b0;
      wt(6);
    end
  endtask : refp

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out

  initial begin
    rst_n_i = 1'b0;
    chip_enable_i = 1'b1;
    ref_div_out_i = 1'b0;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    wt(4);
    for (int k = 0; k < 3; k++) begin
      r = rnd(SEL_REF);
      c = rnd(SEL_CTRL);
      f = rnd(SEL_FB);
      wr(r);
      chk(32'(ref_o), 32'(r[21:2]), "ref");
      wr(c);
      chk(32'(ctrl_o), x_ctrl(c), "ctrl");
      chk(32'(pd_o), x_pd(1'b0, c[9]), "pd run");
      chk(32'(pump_gain_sel_o), 32'(c[10]), "gain c");
      host_u.settle();
      wr(f);
      chk(32'(fb_o), x_fb(f), "fb");
      chk(32'(pump_gain_sel_o), 32'(f[21]), "gain f");
      chk(32'(band_select_active_o), 32'h1, "band on");
      refp(4);
      chk(32'(band_select_active_o), 32'h1, "band 4");
      refp(1);
      chk(32'(band_select_active_o), 32'h0, "band 5");
      $display("test order %0d done", k);
    end
    // halved band clock: five ticks take nine reference rises
    r = rnd(SEL_REF) | 24'h100000;
    wr(r);
    chk(32'(ref_o.band_clk_div), 32'h1, "bsc code");
    wr(f);
    refp(8);
    chk(32'(band_select_active_o), 32'h1, "band 8 of 9");
    refp(1);
    chk(32'(band_select_active_o), 32'h0, "band 9 of 9");
    $display("test band clock done");
    t0 = n_test;
    wr(rnd(SEL_TEST));
    chk(32'(n_test - t0), 32'h1, "test pulse");
    chk(32'(ctrl_o), x_ctrl(c), "ctrl kept");
    chk(32'(fb_o), x_fb(f), "fb kept");
    $display("test code 11 done");
    wr(c | 24'h100000);
    chk(32'(pd_o), x_pd(1'b1, 1'b0), "async pd");
    r = rnd(SEL_REF);
    wr(r);
    chk(32'(ref_o), 32'(r[21:2]), "ref in pd");
    wr(c);
    chk(32'(pd_o), x_pd(1'b0, c[9]), "up");
    chk(32'(fb_o), x_fb(f), "fb after up");
    $display("test async done");
    wr(c | 24'h300000);
    chk(32'(pd_o.powered_down), 32'h0, "sync 0");
    refp(1);
    chk(32'(pd_o.powered_down), 32'h0, "sync 1");
    refp(1);
    chk(32'(pd_o), x_pd(1'b1, 1'b0), "sync 2");
    wr(c);
    $display("test sync done");
    wr(c | 24'h300000);
    wr(c | 24'h100000);
    chk(32'(pd_o), x_pd(1'b1, 1'b0), "async over sync");
    wr(c);
    chk(32'(pd_o.powered_down), 32'h0, "up again");
    $display("test override done");
    @(posedge clk_i);
    chip_enable_i <= 1'b0;
    wt(4);
    chk(32'(pd_o), x_pd(1'b1, 1'b0), "ce low");
    @(posedge clk_i);
    chip_enable_i <= 1'b1;
    wt(4);
    chk(32'(pd_o), x_pd(1'b0, c[9]), "ce high");
    $display("test chip enable done");
    close_out();
  end

  // run needs about 4500 cycles
  initial begin
    repeat (40000) @(posedge clk_i);
    n_fail++;
    close_out();
  end
endmodule : tb

bind pslp_latch_bank pslp_props chk_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .chip_enable_i(chip_enable_i), .ctrl_o(ctrl_o), .fb_o(fb_o), .ref_o(ref_o),
  .pd_o(pd_o), .band_select_active_o(band_select_active_o),
  .test_latch_write_o(test_latch_write_o));

/* File: verilog/pslp_latch_bank.sv */
`timescale 1ns/1ps
module pslp_latch_bank
  import pslp_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // serial programming pins
  input wire logic sclk_i,
  input wire logic sdata_i,
  input wire logic load_strobe_i,
  input wire logic chip_enable_i,
  // reference divider output, from analog side
  input wire logic ref_div_out_i,
  // latched fields
  output pslp_ctrl_t ctrl_o,
  output pslp_fb_t fb_o,
  output pslp_ref_t ref_o,
  output logic pump_gain_sel_o,
  // power-down effects
  output pslp_pd_t pd_o,
  // band selection and test latch write flag
  output logic band_select_active_o,
  output logic test_latch_write_o
);

  typedef enum {
    PD_RUN,
    PD_WAIT_SYNC,
    PD_DOWN
  } pslp_pd_state_t;

  typedef struct packed {
    logic [WORD_W-1:0] ctrl_word;
    logic [WORD_W-1:0] fb_word;
    logic [WORD_W-1:0] ref_word;
    logic gain;
    pslp_pd_state_t pd_state;
    logic [1:0] edge_cnt;
    logic ref_d;
    logic [2:0] bsc_cnt;
    logic [2:0] band_cnt;
    logic band_active;
    logic test_wr;
  } pslp_bank_st_t;

  pslp_bank_st_t st_reg;
  pslp_bank_st_t st_next;

  logic sclk_s;
  logic sdata_s;
  logic load_s;
  logic ce_s;
  logic ref_s;
  logic [WORD_W-1:0] word;
  logic load;
  logic ref_rise;
  logic band_tick;
  logic [2:0] bsc_mask;
  logic down;
  logic ctrl_load;
  logic fb_load;
  logic pd_req;
  logic pd_sync;

  // pins are asynchronous to clk_i
  pslp_sync2 #(
    .W(5)
  ) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .d_i({sclk_i, sdata_i, load_strobe_i, chip_enable_i, ref_div_out_i}),
    .q_o({sclk_s, sdata_s, load_s, ce_s, ref_s})
  );

  // runs regardless of power-down state
  pslp_shift_in u_shift (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .sclk_i(sclk_s),
    .sdata_i(sdata_s),
    .load_strobe_i(load_s),
    .word_o(word),
    .load_o(load)
  );

  function automatic logic [2:0] bsc_div_mask(input logic [1:0] code);
    case (code)
      2'h0: bsc_div_mask = 3'h0;
      2'h1: bsc_div_mask = 3'h1;
      2'h2: bsc_div_mask = 3'h3;
      default: bsc_div_mask = 3'h7;
    endcase
  endfunction : bsc_div_mask

  function automatic logic sel_is(input logic [WORD_W-1:0] w, input logic [1:0] code);
    sel_is = (w[1:0] == code);
  endfunction : sel_is

  assign ref_rise = ref_s && !st_reg.ref_d;
  assign bsc_mask = bsc_div_mask(st_reg.ref_word[RW_BSC_HI:RW_BSC_LO]);
  // divide by 1,2,4,8: tick when masked count wraps
  assign band_tick = ref_rise && ((st_reg.bsc_cnt & bsc_mask) == 3'h0);
  assign down = (st_reg.pd_state == PD_DOWN) || !ce_s;
  // this decode of the latch address serves the control and feedback load paths only
  assign ctrl_load = load && sel_is(word, SEL_CTRL);
  assign fb_load = load && sel_is(word, SEL_FB);
  assign pd_req = word[CW_PD_REQ];
  assign pd_sync = word[CW_PD_SYNC];

  always_comb begin
    st_next = st_reg;
    st_next.ref_d = ref_s;
    st_next.test_wr = 1'b0;
    if (ref_rise) begin
      st_next.bsc_cnt = st_reg.bsc_cnt + 3'h1;
    end
    if (load) begin
      case (word[1:0])
        SEL_CTRL: begin
          st_next.ctrl_word = word;
          st_next.gain = word[CW_GAIN];
        end
        SEL_FB: begin
          st_next.fb_word = word;
          st_next.gain = word[FW_GAIN];
        end
        SEL_REF: begin
          st_next.ref_word = word;
        end
        default: begin
          // test latch words are dropped, only flagged
          st_next.test_wr = 1'b1;
        end
      endcase
    end
    // power-down sequencing
    case (st_reg.pd_state)
      PD_RUN: begin
        if (ctrl_load && pd_req) begin
          if (!pd_sync) begin
            st_next.pd_state = PD_DOWN;
          end else begin
            st_next.pd_state = PD_WAIT_SYNC;
            st_next.edge_cnt = 2'h0;
          end
        end
      end
      PD_WAIT_SYNC: begin
        if (ctrl_load) begin
          // the newest control word overrides a pending request
          if (!pd_req) begin
            st_next.pd_state = PD_RUN;
          end else if (!pd_sync) begin
            st_next.pd_state = PD_DOWN;
          end else begin
            st_next.edge_cnt = 2'h0;
          end
        end else if (ref_rise) begin
          st_next.edge_cnt = st_reg.edge_cnt + 2'h1;
          if (st_reg.edge_cnt + 2'h1 == PD_SYNC_EDGES) begin
            st_next.pd_state = PD_DOWN;
          end
        end
      end
      PD_DOWN: begin
        // a later request-clear word powers back up, band select stays off until a feedback load
        if (ctrl_load && !pd_req) begin
          st_next.pd_state = PD_RUN;
        end
      end
      default: begin
        st_next.pd_state = PD_RUN;
      end
    endcase
    // band select counts band clock ticks, cancelled while down
    if (fb_load) begin
      // a fresh load restarts the count in phase and wins over its end
      st_next.band_active = 1'b1;
      st_next.band_cnt = 3'h0;
      st_next.bsc_cnt = 3'h0;
    end else if (down) begin
      st_next.bsc_cnt = 3'h0;
      st_next.band_active = 1'b0;
    end else if (st_reg.band_active && band_tick) begin
      st_next.band_cnt = st_reg.band_cnt + 3'h1;
      if (st_reg.band_cnt + 3'h1 == BAND_CYCLES) begin
        st_next.band_active = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_reg <= '{ctrl_word: WORD_RESET, fb_word: WORD_RESET, ref_word: WORD_RESET,
                  gain: 1'b0, pd_state: PD_RUN, edge_cnt: 2'h0, ref_d: 1'b0,
                  bsc_cnt: 3'h0, band_cnt: 3'h0,
                  band_active: 1'b0, test_wr: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  // field decode
  always_comb begin
    ctrl_o.prescaler_sel = st_reg.ctrl_word[CW_PRESC_HI:CW_PRESC_LO];
    ctrl_o.powerdown_sync_sel = st_reg.ctrl_word[CW_PD_SYNC];
    ctrl_o.powerdown_request = st_reg.ctrl_word[CW_PD_REQ];
    ctrl_o.pump_current_b = st_reg.ctrl_word[CW_CUR_B_HI:CW_CUR_B_LO];
    ctrl_o.pump_current_a = st_reg.ctrl_word[CW_CUR_A_HI:CW_CUR_A_LO];
    ctrl_o.rf_level = st_reg.ctrl_word[CW_LVL_HI:CW_LVL_LO];
    ctrl_o.mute_until_locked = st_reg.ctrl_word[CW_MUTE];
    ctrl_o.pump_tristate = st_reg.ctrl_word[CW_TRI];
    ctrl_o.detector_polarity = st_reg.ctrl_word[CW_POL];
    ctrl_o.outmux_sel = st_reg.ctrl_word[CW_MUX_HI:CW_MUX_LO];
    ctrl_o.divider_clear = st_reg.ctrl_word[CW_CLR];
    ctrl_o.core_level = st_reg.ctrl_word[CW_CORE_HI:CW_CORE_LO];
    fb_o.halved_prescaler_source = st_reg.fb_word[FW_SRC];
    fb_o.output_halving = st_reg.fb_word[FW_HALF];
    fb_o.main_count = st_reg.fb_word[FW_MAIN_HI:FW_MAIN_LO];
    fb_o.swallow_count = st_reg.fb_word[FW_SWAL_HI:FW_SWAL_LO];
    ref_o.band_clk_div = st_reg.ref_word[RW_BSC_HI:RW_BSC_LO];
    ref_o.factory_test_enable = st_reg.ref_word[RW_TEST];
    ref_o.lock_precision = st_reg.ref_word[RW_LDP];
    ref_o.antibacklash_width = st_reg.ref_word[RW_ABP_HI:RW_ABP_LO];
    ref_o.ref_ratio = st_reg.ref_word[RW_RATIO_HI:RW_RATIO_LO];
  end

  // effects follow the power-down level, pump_hiz also follows the tristate bit
  always_comb begin
    pd_o.powered_down = down;
    pd_o.dividers_held = down;
    pd_o.pump_hiz = down || st_reg.ctrl_word[CW_TRI];
    pd_o.lock_reset = down;
    pd_o.rf_hiz = down;
    pd_o.ref_buf_off = down;
  end

  // latest write from either word wins
  assign pump_gain_sel_o = st_reg.gain;
  assign band_select_active_o = st_reg.band_active;
  assign test_latch_write_o = st_reg.test_wr;

endmodule : pslp_latch_bank

/* File: verilog/pslp_pkg.sv */
package pslp_pkg;

  // serial word geometry
  localparam int WORD_W = 24;
  localparam int CNT_W = 5;
  localparam logic [1:0] SEL_CTRL = 2'h0;
  localparam logic [1:0] SEL_REF = 2'h1;
  localparam logic [1:0] SEL_FB = 2'h2;
  localparam logic [1:0] SEL_TEST = 2'h3;
  localparam logic [23:0] WORD_RESET = 24'h000000;

  // control word fields
  localparam int CW_PRESC_HI = 23;
  localparam int CW_PRESC_LO = 22;
  localparam int CW_PD_SYNC = 21;
  localparam int CW_PD_REQ = 20;
  localparam int CW_CUR_B_HI = 19;
  localparam int CW_CUR_B_LO = 17;
  localparam int CW_CUR_A_HI = 16;
  localparam int CW_CUR_A_LO = 14;
  localparam int CW_LVL_HI = 13;
  localparam int CW_LVL_LO = 12;
  localparam int CW_MUTE = 11;
  localparam int CW_GAIN = 10;
  localparam int CW_TRI = 9;
  localparam int CW_POL = 8;
  localparam int CW_MUX_HI = 7;
  localparam int CW_MUX_LO = 5;
  localparam int CW_CLR = 4;
  localparam int CW_CORE_HI = 3;
  localparam int CW_CORE_LO = 2;

  // feedback word fields
  localparam int FW_SRC = 23;
  localparam int FW_HALF = 22;
  localparam int FW_GAIN = 21;
  localparam int FW_MAIN_HI = 20;
  localparam int FW_MAIN_LO = 8;
  localparam int FW_SWAL_HI = 6;
  localparam int FW_SWAL_LO = 2;

  // reference word fields
  localparam int RW_BSC_HI = 21;
  localparam int RW_BSC_LO = 20;
  localparam int RW_TEST = 19;
  localparam int RW_LDP = 18;
  localparam int RW_ABP_HI = 17;
  localparam int RW_ABP_LO = 16;
  localparam int RW_RATIO_HI = 15;
  localparam int RW_RATIO_LO = 2;

  // band selection length in band clock ticks
  localparam logic [2:0] BAND_CYCLES = 3'h5;
  localparam logic [1:0] PD_SYNC_EDGES = 2'h2;

  typedef struct packed {
    logic [1:0] prescaler_sel;
    logic powerdown_sync_sel;
    logic powerdown_request;
    logic [2:0] pump_current_b;
    logic [2:0] pump_current_a;
    logic [1:0] rf_level;
    logic mute_until_locked;
    logic pump_tristate;
    logic detector_polarity;
    logic [2:0] outmux_sel;
    logic divider_clear;
    logic [1:0] core_level;
  } pslp_ctrl_t;

  typedef struct packed {
    logic halved_prescaler_source;
    logic output_halving;
    logic [12:0] main_count;
    logic [4:0] swallow_count;
  } pslp_fb_t;

  typedef struct packed {
    logic [1:0] band_clk_div;
    logic factory_test_enable;
    logic lock_precision;
    logic [1:0] antibacklash_width;
    logic [13:0] ref_ratio;
  } pslp_ref_t;

  typedef struct packed {
    logic powered_down;
    logic dividers_held;
    logic pump_hiz;
    logic lock_reset;
    logic rf_hiz;
    logic ref_buf_off;
  } pslp_pd_t;

endpackage : pslp_pkg

/* File: verilog/pslp_shift_in.sv */
`timescale 1ns/1ps
module pslp_shift_in
  import pslp_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // synced serial pins
  input wire logic sclk_i,
  input wire logic sdata_i,
  input wire logic load_strobe_i,
  // captured word
  output logic [WORD_W-1:0] word_o,
  output logic load_o
);

  typedef struct packed {
    logic sclk_d;
    logic load_d;
    logic [WORD_W-1:0] shift;
  } pslp_sh_st_t;

  pslp_sh_st_t st_reg;
  pslp_sh_st_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.sclk_d = sclk_i;
    st_next.load_d = load_strobe_i;
    // msb first, new bit enters at the bottom
    if (sclk_i && !st_reg.sclk_d) begin
      st_next.shift = {st_reg.shift[WORD_W-2:0], sdata_i};
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign word_o = st_reg.shift;
  assign load_o = load_strobe_i && !st_reg.load_d;

endmodule : pslp_shift_in

/* File: verilog/pslp_sync2.sv */
`timescale 1ns/1ps
module pslp_sync2
  import pslp_pkg::*;
#(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // async in, synced out
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pslp_sync_st_t;

  pslp_sync_st_t st_reg;
  pslp_sync_st_t st_next;

  always_comb begin
    st_next.s1 = d_i;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q_o = st_reg.s2;

endmodule : pslp_sync2
